// *** shared/duhbsr_pkg.sv ***
// Shared constants and types for the dual UART host bus front end.
// Assumes one 50 MHz clock and a synchronous active-high system reset.
`default_nettype none
package duhbsr_pkg;

  // ===========================================================================
  // Clock and reset timing
  localparam int CLK_PERIOD_NS = 20;
  localparam int RST_MIN_NS    = 40;
  localparam int RST_MIN_CYC_I = (RST_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RST_MIN_CYC   = (RST_MIN_CYC_I < 1) ? 1 : RST_MIN_CYC_I;
  localparam logic [3:0] RST_CNT_LAST = 4'(RST_MIN_CYC - 1);

  // ===========================================================================
  // Bus style pin level and channel count
  localparam logic BUS_STROBE = 1'b1;
  localparam int   NUM_CHAN   = 2;

  // ===========================================================================
  // Per-channel register offsets
  localparam logic [2:0] ADDR_DATA = 3'h0;
  localparam logic [2:0] ADDR_IER  = 3'h1;
  localparam logic [2:0] ADDR_ISR  = 3'h2;
  localparam logic [2:0] ADDR_LCR  = 3'h3;
  localparam logic [2:0] ADDR_MCR  = 3'h4;
  localparam logic [2:0] ADDR_LSR  = 3'h5;
  localparam logic [2:0] ADDR_MSR  = 3'h6;
  localparam logic [2:0] ADDR_SPR  = 3'h7;

  // ===========================================================================
  // Field positions and keys
  localparam logic [7:0] LCR_ENH_KEY   = 8'hBF;
  localparam int         LCR_DLAB_BIT  = 7;
  localparam int         EFR_ENH_BIT   = 4;
  localparam int         MCR_PRESC_BIT = 7;
  localparam int         FCR_EN_BIT    = 0;
  localparam int         FCR_RXCLR_BIT = 1;
  localparam int         FCR_TXCLR_BIT = 2;
  localparam int         IER_RX_BIT    = 0;
  localparam int         IER_TX_BIT    = 1;
  localparam logic [7:0] ISR_NONE      = 8'h01;
  localparam logic [7:0] ISR_TX        = 8'h02;
  localparam logic [7:0] ISR_RX        = 8'h04;
  localparam logic [7:0] MSR_VALUE     = 8'h00;

  // ===========================================================================
  // Values after reset
  localparam logic [7:0] RST_REG8 = 8'h00;

  // ===========================================================================
  // Sampling and prescaler
  typedef enum logic [1:0] {SAMP_16X, SAMP_8X, SAMP_4X} duhbsr_samp_t;
  localparam logic [4:0] SAMP_N16 = 5'h10;
  localparam logic [4:0] SAMP_N8  = 5'h08;
  localparam logic [4:0] SAMP_N4  = 5'h04;
  localparam logic [1:0] PRESC_LAST = 2'h3;

  function automatic duhbsr_samp_t duhbsr_samp_decode(input logic [1:0] code);
    return (code == 2'h1) ? SAMP_8X : (code[1] ? SAMP_4X : SAMP_16X);
  endfunction

  function automatic logic [4:0] duhbsr_samp_count(input duhbsr_samp_t mode);
    return (mode == SAMP_8X) ? SAMP_N8 : ((mode == SAMP_4X) ? SAMP_N4 : SAMP_N16);
  endfunction

endpackage
`default_nettype wire

// *** hdl/duhbsr_serial.sv ***
// Baud generator, transmitter and receiver of one UART channel, 8N1 framing.
// Assumes rst is the channel reset and rx_in is synchronous to clk.
`timescale 1ns/100ps
`default_nettype none
module duhbsr_serial (
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic [15:0]            divisor,
  input  wire logic [3:0]             frac,
  input  wire duhbsr_pkg::duhbsr_samp_t samp_mode,
  input  wire logic                   presc_div4,
  input  wire logic                   tx_valid,
  input  wire logic [7:0]             tx_data,
  output logic                        tx_pop,
  output logic                        tx_busy,
  input  wire logic                   rx_in,
  output logic                        rx_valid,
  output logic [7:0]                  rx_data,
  output logic                        tx_out
);
  import duhbsr_pkg::*;

  // ===========================================================================
  // Prescaler and fractional divider
  logic [1:0]  pre_cnt_q;
  logic [15:0] int_cnt_q;
  logic [3:0]  frac_acc_q;
  logic [4:0]  frac_sum;
  logic        pre_en;
  logic        samp_en;
  logic [4:0]  os_n;
  logic [4:0]  os_mid;

  assign pre_en   = presc_div4 ? (pre_cnt_q == PRESC_LAST) : 1'b1;
  assign samp_en  = pre_en && (int_cnt_q == 16'h0000) && (divisor != 16'h0000);
  assign frac_sum = {1'b0, frac_acc_q} + {1'b0, frac};
  assign os_n     = duhbsr_samp_count(samp_mode);
  assign os_mid   = (os_n >> 1) - 5'h01;

  always_ff @(posedge clk) begin
    if (rst) begin
      pre_cnt_q  <= 2'h0;
      int_cnt_q  <= 16'h0000;
      frac_acc_q <= 4'h0;
    end else begin
      pre_cnt_q <= pre_cnt_q + 2'h1;
      if (pre_en) begin
        if (int_cnt_q == 16'h0000) begin
          // Carry from the fraction stretches one period by one prescaled tick: a cycle, or four cycles with presc_div4
          int_cnt_q  <= (divisor == 16'h0000) ? 16'h0000 : divisor - 16'h0001 + {15'h0000, frac_sum[4]};
          frac_acc_q <= frac_sum[3:0];
        end else begin
          int_cnt_q <= int_cnt_q - 16'h0001;
        end
      end
    end
  end

  // ===========================================================================
  // Transmitter
  logic [9:0] tx_sh_q;
  logic [4:0] tx_os_q;
  logic [3:0] tx_bit_q;

  assign tx_pop = samp_en && !tx_busy && tx_valid;
  assign tx_out = tx_sh_q[0];

  always_ff @(posedge clk) begin
    if (rst) begin
      tx_sh_q  <= 10'h3FF;
      tx_busy  <= 1'b0;
      tx_os_q  <= 5'h00;
      tx_bit_q <= 4'h0;
    end else if (tx_pop) begin
      tx_sh_q  <= {1'b1, tx_data, 1'b0};
      tx_busy  <= 1'b1;
      tx_os_q  <= 5'h00;
      tx_bit_q <= 4'h0;
    end else if (samp_en && tx_busy) begin
      tx_os_q <= tx_os_q + 5'h01;
      if (tx_os_q == os_n - 5'h01) begin
        tx_os_q  <= 5'h00;
        tx_sh_q  <= {1'b1, tx_sh_q[9:1]};
        tx_bit_q <= tx_bit_q + 4'h1;
        tx_busy  <= (tx_bit_q != 4'h9);
      end
    end
  end

  // ===========================================================================
  // Receiver, sampling each bit in its middle
  logic       rx_busy_q;
  logic [4:0] rx_os_q;
  logic [3:0] rx_bit_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_busy_q <= 1'b0;
      rx_os_q   <= 5'h00;
      rx_bit_q  <= 4'h0;
      rx_data   <= 8'h00;
      rx_valid  <= 1'b0;
    end else begin
      rx_valid <= 1'b0;
      if (samp_en && !rx_busy_q && !rx_in) begin
        rx_busy_q <= 1'b1;
        rx_os_q   <= 5'h00;
        rx_bit_q  <= 4'h0;
      end else if (samp_en && rx_busy_q) begin
        rx_os_q <= rx_os_q + 5'h01;
        if (rx_os_q == os_mid) begin
          if (rx_bit_q == 4'h0) begin
            rx_busy_q <= !rx_in;
          end else if (rx_bit_q == 4'h9) begin
            rx_busy_q <= 1'b0;
            rx_valid  <= rx_in;
          end else begin
            rx_data <= {rx_in, rx_data[7:1]};
          end
        end
        if (rx_os_q == os_n - 5'h01) begin
          rx_os_q  <= 5'h00;
          rx_bit_q <= rx_bit_q + 4'h1;
        end
      end
    end
  end

endmodule
`default_nettype wire

// *** hdl/duhbsr_top.sv ***
// Host bus front end of a dual UART: bus style select, reset, channel decode,
// and the register sets and FIFOs of both channels.
// Assumes all pins are synchronous to clk and each strobe lasts two clocks or more.
`timescale 1ns/100ps
`default_nettype none
module duhbsr_top #(
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic       clk,
  input  wire logic       srst,
  input  wire logic       bus_mode_sel,
  input  wire logic       reset_in,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       chan_a_select_n,
  input  wire logic       chan_b_select_n,
  input  wire logic       chip_select_n,
  input  wire logic       rd_wr_n,
  input  wire logic       channel_address_bit,
  input  wire logic [2:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe,
  input  wire logic [1:0] rx_in,
  output logic      [1:0] tx_out
);
  import duhbsr_pkg::*;

  localparam int AW = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (1 << AW) != FIFO_DEPTH) begin : g_depth_check
    $error("FIFO_DEPTH must be a power of two of at least two");
  end

  // ===========================================================================
  // Bus style and reset
  logic       strobe_mode;
  logic       reset_act;
  logic [3:0] rst_cnt_q;
  logic       chan_rst_q;

  assign strobe_mode = (bus_mode_sel == BUS_STROBE);
  assign reset_act   = strobe_mode ? reset_in : !reset_in;

  // Short glitches on the reset pin are filtered; a pulse of the least width resets
  always_ff @(posedge clk) begin
    if (srst || !reset_act) begin
      rst_cnt_q <= 4'h0;
    end else if (rst_cnt_q != RST_CNT_LAST) begin
      rst_cnt_q <= rst_cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    chan_rst_q <= srst || (reset_act && (rst_cnt_q == RST_CNT_LAST));
  end

  // ===========================================================================
  // Channel select and access decode
  logic [1:0] sel_strobe;
  logic [1:0] sel_line;
  logic [1:0] sel;
  logic       rd_act;
  logic       wr_act;
  logic       acc_rd;
  logic       acc_wr;
  logic       acc_rd_q;
  logic       acc_wr_q;
  logic [1:0] sel_q;
  logic [2:0] addr_q;
  logic [7:0] wdata_q;
  logic       rd_end;
  logic       wr_end;

  assign sel_strobe = {!chan_b_select_n, !chan_a_select_n};
  assign sel_line   = chip_select_n ? 2'b00 : (channel_address_bit ? 2'b10 : 2'b01);
  assign sel        = strobe_mode ? sel_strobe : sel_line;
  assign rd_act     = strobe_mode ? !read_strobe_n : rd_wr_n;
  assign wr_act     = strobe_mode ? !write_strobe_n : !rd_wr_n;
  assign acc_rd     = (|sel) && rd_act && !chan_rst_q;
  assign acc_wr     = (|sel) && wr_act && !chan_rst_q;
  // Writes commit and reads pop at the trailing edge of the host's cycle
  assign rd_end     = acc_rd_q && !acc_rd;
  assign wr_end     = acc_wr_q && !acc_wr;

  always_ff @(posedge clk) begin
    if (srst) begin
      acc_rd_q <= 1'b0;
      acc_wr_q <= 1'b0;
      sel_q    <= 2'b00;
      addr_q   <= 3'h0;
      wdata_q  <= 8'h00;
    end else begin
      acc_rd_q <= acc_rd;
      acc_wr_q <= acc_wr;
      if (acc_rd || acc_wr) begin
        sel_q   <= sel;
        addr_q  <= addr;
        wdata_q <= data_in;
      end
    end
  end

  // ===========================================================================
  // Read data path
  logic [7:0] ch_rdata [NUM_CHAN];
  logic [7:0] rd_mux;

  // Reading both channels at once is illegal; channel A then wins
  assign rd_mux = sel[0] ? ch_rdata[0] : ch_rdata[1];

  always_ff @(posedge clk) begin
    if (srst) begin
      data_out <= 8'h00;
      data_oe  <= 1'b0;
    end else begin
      data_out <= acc_rd ? rd_mux : 8'h00;
      data_oe  <= acc_rd;
    end
  end

  // ===========================================================================
  // Per-channel register sets and FIFOs
  for (genvar ch = 0; ch < NUM_CHAN; ch++) begin : g_chan
    logic [7:0]  ier_q, lcr_q, mcr_q, spr_q, dll_q, dlm_q, dld_q, efr_q;
    logic        fifo_en_q;
    logic        ovr_q;
    logic [7:0]  tx_mem [FIFO_DEPTH];
    logic [7:0]  rx_mem [FIFO_DEPTH];
    logic [AW:0] tx_wp_q, tx_rp_q, rx_wp_q, rx_rp_q;
    logic        dlab, enh_page, enh_on;
    logic        wr_ev, rd_ev;
    logic        w_thr, w_fcr, w_efr, w_dld, pop_rhr, rd_lsr;
    logic        tx_empty, tx_full, rx_empty, rx_full;
    logic        tx_pop, tx_busy, rx_valid;
    logic        fcr_rxclr, fcr_txclr;
    logic [7:0]  rx_byte, isr, lsr;

    assign dlab     = lcr_q[LCR_DLAB_BIT];
    assign enh_page = (lcr_q == LCR_ENH_KEY);
    assign enh_on   = efr_q[EFR_ENH_BIT];
    assign wr_ev    = wr_end && sel_q[ch];
    assign rd_ev    = rd_end && sel_q[ch];
    assign w_thr    = wr_ev && (addr_q == ADDR_DATA) && !dlab;
    assign w_fcr    = wr_ev && (addr_q == ADDR_ISR) && !dlab;
    assign w_efr    = wr_ev && (addr_q == ADDR_ISR) && enh_page;
    assign w_dld    = wr_ev && (addr_q == ADDR_ISR) && dlab && !enh_page && enh_on;
    assign pop_rhr  = rd_ev && (addr_q == ADDR_DATA) && !dlab && !rx_empty;
    assign rd_lsr   = rd_ev && (addr_q == ADDR_LSR);
    assign fcr_rxclr = w_fcr && wdata_q[FCR_RXCLR_BIT];
    assign fcr_txclr = w_fcr && wdata_q[FCR_TXCLR_BIT];

    assign tx_empty = (tx_wp_q == tx_rp_q);
    assign tx_full  = (tx_wp_q[AW] != tx_rp_q[AW]) && (tx_wp_q[AW-1:0] == tx_rp_q[AW-1:0]);
    assign rx_empty = (rx_wp_q == rx_rp_q);
    assign rx_full  = (rx_wp_q[AW] != rx_rp_q[AW]) && (rx_wp_q[AW-1:0] == rx_rp_q[AW-1:0]);

    assign isr = {fifo_en_q, fifo_en_q, 2'b00,
                  (ier_q[IER_RX_BIT] && !rx_empty) ? ISR_RX[3:0] :
                  ((ier_q[IER_TX_BIT] && tx_empty) ? ISR_TX[3:0] : ISR_NONE[3:0])};
    assign lsr = {1'b0, tx_empty && !tx_busy, tx_empty, 3'b000, ovr_q, !rx_empty};

    assign ch_rdata[ch] =
      (addr_q == ADDR_DATA) ? (dlab ? dll_q : rx_mem[rx_rp_q[AW-1:0]]) :
      (addr_q == ADDR_IER)  ? (dlab ? dlm_q : ier_q) :
      (addr_q == ADDR_ISR)  ? (enh_page ? efr_q : (dlab ? dld_q : isr)) :
      (addr_q == ADDR_LCR)  ? lcr_q :
      (addr_q == ADDR_MCR)  ? mcr_q :
      (addr_q == ADDR_LSR)  ? lsr :
      (addr_q == ADDR_MSR)  ? MSR_VALUE : spr_q;

    always_ff @(posedge clk) begin
      if (chan_rst_q) begin
        ier_q <= RST_REG8;
        lcr_q <= RST_REG8;
        mcr_q <= RST_REG8;
        spr_q <= RST_REG8;
        dll_q <= RST_REG8;
        dlm_q <= RST_REG8;
        dld_q <= RST_REG8;
        efr_q <= RST_REG8;
        fifo_en_q <= 1'b0;
      end else if (wr_ev) begin
        if (addr_q == ADDR_DATA && dlab) dll_q <= wdata_q;
        if (addr_q == ADDR_IER && !dlab) ier_q <= wdata_q;
        if (addr_q == ADDR_IER && dlab) dlm_q <= wdata_q;
        if (addr_q == ADDR_LCR) lcr_q <= wdata_q;
        // Prescaler select is an enhanced feature and stays at divide-by-one until enabled
        if (addr_q == ADDR_MCR) mcr_q <= {wdata_q[MCR_PRESC_BIT] && enh_on, wdata_q[6:0]};
        if (addr_q == ADDR_SPR) spr_q <= wdata_q;
        if (w_efr) efr_q <= wdata_q;
        if (w_dld) dld_q <= wdata_q;
        if (w_fcr) fifo_en_q <= wdata_q[FCR_EN_BIT];
      end
    end

    // Overrun: a new byte lost in the clearing cycle still sets the flag
    always_ff @(posedge clk) begin
      if (chan_rst_q) begin
        ovr_q <= 1'b0;
      end else begin
        ovr_q <= (rx_valid && rx_full) || (ovr_q && !rd_lsr);
      end
    end

    // A byte written to a full transmit FIFO is dropped
    always_ff @(posedge clk) begin
      if (chan_rst_q || fcr_txclr) begin
        tx_wp_q <= '0;
        tx_rp_q <= '0;
      end else begin
        if (w_thr && !tx_full) tx_wp_q <= tx_wp_q + 1'b1;
        if (tx_pop) tx_rp_q <= tx_rp_q + 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (chan_rst_q || fcr_rxclr) begin
        rx_wp_q <= '0;
        rx_rp_q <= '0;
      end else begin
        if (rx_valid && !rx_full) rx_wp_q <= rx_wp_q + 1'b1;
        if (pop_rhr) rx_rp_q <= rx_rp_q + 1'b1;
      end
    end

    always_ff @(posedge clk) begin
      if (w_thr && !tx_full) tx_mem[tx_wp_q[AW-1:0]] <= wdata_q;
      if (rx_valid && !rx_full) rx_mem[rx_wp_q[AW-1:0]] <= rx_byte;
    end

    duhbsr_serial u_serial (
      .clk        (clk),
      .rst        (chan_rst_q),
      .divisor    ({dlm_q, dll_q}),
      .frac       (dld_q[3:0]),
      .samp_mode  (duhbsr_samp_decode(dld_q[5:4])),
      .presc_div4 (mcr_q[MCR_PRESC_BIT]),
      .tx_valid   (!tx_empty),
      .tx_data    (tx_mem[tx_rp_q[AW-1:0]]),
      .tx_pop     (tx_pop),
      .tx_busy    (tx_busy),
      .rx_in      (rx_in[ch]),
      .rx_valid   (rx_valid),
      .rx_data    (rx_byte),
      .tx_out     (tx_out[ch])
    );
  end

endmodule
`default_nettype wire

// *** verification/duhbsr_top_monitor.sv ***
// Concurrent checks on the host port and serial idle behaviour of duhbsr_top.
// Assumes it is bound to duhbsr_top and sees only that module's ports.
`timescale 1ns/100ps
`default_nettype none
module duhbsr_top_monitor (
  input wire logic       clk,
  input wire logic       srst,
  input wire logic       bus_mode_sel,
  input wire logic       reset_in,
  input wire logic       read_strobe_n,
  input wire logic       write_strobe_n,
  input wire logic       chan_a_select_n,
  input wire logic       chan_b_select_n,
  input wire logic       chip_select_n,
  input wire logic       rd_wr_n,
  input wire logic       channel_address_bit,
  input wire logic [2:0] addr,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic [1:0] rx_in,
  input wire logic [1:0] tx_out
);
  import duhbsr_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ===========================================================================
  // Decoded pin activity
  wire logic       rst_act = bus_mode_sel ? reset_in : !reset_in;
  wire logic       sel_s   = !chan_a_select_n || !chan_b_select_n;
  wire logic       rd_any  = bus_mode_sel ? (sel_s && !read_strobe_n) : (!chip_select_n && rd_wr_n);
  logic      [2:0] quiet_q;
  // Clean cycles since any reset; accesses right after reset may be refused
  wire logic [2:0] quiet_d = (srst || rst_act) ? 3'h0 : ((quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1);
  wire logic       quiet   = (quiet_q == 3'h7);
  always_ff @(posedge clk) begin
    quiet_q <= quiet_d;
  end
  // ===========================================================================
  // Assertions
  property p_tx_rst; rst_act [*4] |=> tx_out == 2'h3; endproperty
  a_tx_rst: assert property (p_tx_rst) else $error("transmit not idle in reset");
  property p_tx_hold; rst_act [*6] |-> $stable(tx_out); endproperty
  a_tx_hold: assert property (p_tx_hold) else $error("transmit moved in reset");
  property p_rst_quiet; rst_act [*4] |=> !data_oe; endproperty
  a_rst_quiet: assert property (p_rst_quiet) else $error("read served in reset");
  property p_oe_read; quiet && rd_any |=> data_oe; endproperty
  a_oe_read: assert property (p_oe_read) else $error("read not answered");
  property p_oe_drop; !rd_any |=> !data_oe; endproperty
  a_oe_drop: assert property (p_oe_drop) else $error("bus driven without read");
  property p_dout_zero; !data_oe |-> data_out == 8'h00; endproperty
  a_dout_zero: assert property (p_dout_zero) else $error("read data without read");
  property p_msr; (quiet && rd_any && addr == ADDR_MSR) [*3] |=> data_out == MSR_VALUE; endproperty
  a_msr: assert property (p_msr) else $error("modem status value wrong");
  property p_strobe_desel; bus_mode_sel && chan_a_select_n && chan_b_select_n |=> !data_oe; endproperty
  a_strobe_desel: assert property (p_strobe_desel) else $error("strobe bus answered unselected");
  property p_line_desel; !bus_mode_sel && chip_select_n |=> !data_oe; endproperty
  a_line_desel: assert property (p_line_desel) else $error("line bus answered unselected");
  c_strobe_rd: cover property (bus_mode_sel && rd_any ##1 data_oe);
  c_line_rd: cover property (!bus_mode_sel && rd_any ##1 data_oe);
  c_both_wr: cover property (bus_mode_sel && !chan_a_select_n && !chan_b_select_n && !write_strobe_n);
  c_pin_rst: cover property (rst_act [*4]);
endmodule
bind duhbsr_top duhbsr_top_monitor u_mon (.clk, .srst, .bus_mode_sel, .reset_in, .read_strobe_n,
  .write_strobe_n, .chan_a_select_n, .chan_b_select_n, .chip_select_n, .rd_wr_n,
  .channel_address_bit, .addr, .data_in, .data_out, .data_oe, .rx_in, .tx_out);
`default_nettype wire

// *** verification/duhbsr_host.sv ***
// Host processor model for the dual UART host port, both bus styles.
// Assumes the bench sets bus_mode_sel and calls xfer between resets.
`timescale 1ns/100ps
`default_nettype none
module duhbsr_host (
  input  wire logic       clk,
  input  wire logic       bus_mode_sel,
  input  wire logic [7:0] data_out,
  output logic            read_strobe_n,
  output logic            write_strobe_n,
  output logic            chan_a_select_n,
  output logic            chan_b_select_n,
  output logic            chip_select_n,
  output logic            rd_wr_n,
  output logic            channel_address_bit,
  output logic      [2:0] addr,
  output logic      [7:0] data_in
);
  import duhbsr_pkg::*;
  // ===========================================================================
  // Idle bus: released address and data lines do not keep their last value
  task automatic idle();
    read_strobe_n = 1'b1;
    write_strobe_n = 1'b1;
    chan_a_select_n = 1'b1;
    chan_b_select_n = 1'b1;
    chip_select_n = 1'b1;
    rd_wr_n = 1'b1;
    addr = ~addr;
    data_in = ~data_in;
  endtask
  initial begin
    addr = 3'h0;
    data_in = 8'h00;
    idle();
  end
  // ===========================================================================
  // One transfer; ch bit0 picks A, bit1 picks B; both only ever for writes
  task automatic xfer(input logic rd, input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    logic [3:0] junk;
    junk = 4'($urandom);
    @(negedge clk);
    addr = a;
    data_in = d;
    if (bus_mode_sel == BUS_STROBE) begin
      chan_a_select_n = !ch[0];
      chan_b_select_n = !ch[1];
      read_strobe_n = !rd;
      write_strobe_n = rd;
      {chip_select_n, rd_wr_n, channel_address_bit} = junk[2:0];
    end else begin
      chip_select_n = 1'b0;
      rd_wr_n = rd;
      channel_address_bit = ch[1];
      {chan_a_select_n, chan_b_select_n, read_strobe_n, write_strobe_n} = junk;
    end
    // Reads need the strobe two cycles or more before data settles
    repeat (rd ? 4 : 1) @(posedge clk);
    // Sample off the launching edge, while the request still stands
    @(negedge clk);
    q = data_out;
    idle();
    @(negedge clk);
  endtask
endmodule
`default_nettype wire

// *** verification/duhbsr_tb.sv ***
// Self-checking bench for duhbsr_top with a host model and crossed serial lines.
// Assumes the checker file is compiled alongside so that it binds to the design.
`timescale 1ns/100ps
`default_nettype none
module dual_uart_host_bus_select_reset_tb;
  import duhbsr_pkg::*;
  logic            clk = 1'b0;
  logic            srst = 1'b1;
  logic            bus_mode_sel = 1'b1;
  logic            reset_in = 1'b0;
  logic            in_rst = 1'b1;
  wire logic       read_strobe_n, write_strobe_n, chan_a_select_n, chan_b_select_n;
  wire logic       chip_select_n, rd_wr_n, channel_address_bit, data_oe;
  wire logic [2:0] addr;
  wire logic [7:0] data_in, data_out;
  wire logic [1:0] rx_in, tx_out;
  int              failures = 0;
  int              n_checks = 0;
  int              spr_m [2];
  int              rxq [2][$];
  always #10 clk = ~clk;
  // A sends to B and back; a break on the lines in reset must be ignored
  assign rx_in = in_rst ? 2'h0 : {tx_out[0], tx_out[1]};
  duhbsr_top #(.FIFO_DEPTH(16)) dut (.clk, .srst, .bus_mode_sel, .reset_in, .read_strobe_n,
    .write_strobe_n, .chan_a_select_n, .chan_b_select_n, .chip_select_n, .rd_wr_n,
    .channel_address_bit, .addr, .data_in, .data_out, .data_oe, .rx_in, .tx_out);
  duhbsr_host u_host (.clk, .bus_mode_sel, .data_out, .read_strobe_n, .write_strobe_n,
    .chan_a_select_n, .chan_b_select_n, .chip_select_n, .rd_wr_n, .channel_address_bit,
    .addr, .data_in);
  // ===========================================================================
  // Checking and bus tasks
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("BAD %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic wr(input logic [1:0] ch, input logic [2:0] a, input logic [7:0] d);
    logic [7:0] q;
    u_host.xfer(1'b0, ch, a, d, q);
    for (int c = 0; c < 2; c++) if (ch[c] && a == ADDR_SPR) spr_m[c] = d;
  endtask
  task automatic rd_chk(input int c, input logic [2:0] a, input logic [7:0] exp);
    logic [7:0] q;
    u_host.xfer(1'b1, 2'(1 << c), a, 8'h00, q);
    check(q, exp, "read data");
  endtask
  // ===========================================================================
  // Resets; the pin is held far beyond its minimum width
  task automatic do_srst(input logic mode);
    @(negedge clk);
    srst = 1'b1;
    in_rst = 1'b1;
    bus_mode_sel = mode;
    reset_in = !mode;
    repeat (5) @(negedge clk);
    srst = 1'b0;
    in_rst = 1'b0;
    repeat (4) @(negedge clk);
    spr_m = '{0, 0};
  endtask
  task automatic pin_rst();
    @(negedge clk);
    reset_in = bus_mode_sel;
    in_rst = 1'b1;
    repeat (6) @(negedge clk);
    check({6'h00, tx_out}, 8'h03, "transmit idle");
    reset_in = !bus_mode_sel;
    in_rst = 1'b0;
    repeat (4) @(negedge clk);
    spr_m = '{0, 0};
  endtask
  // ===========================================================================
  // Scenarios
  task automatic chk_defaults();
    for (int c = 0; c < 2; c++) begin
      rd_chk(c, ADDR_LCR, RST_REG8);
      rd_chk(c, ADDR_IER, RST_REG8);
      rd_chk(c, ADDR_SPR, RST_REG8);
      rd_chk(c, ADDR_ISR, ISR_NONE);
      rd_chk(c, ADDR_LSR, 8'h60);
      rd_chk(c, ADDR_MSR, MSR_VALUE);
    end
  endtask
  task automatic spr_mix(input int n);
    logic [1:0] ch;
    for (int i = 0; i < n; i++) begin
      ch = bus_mode_sel ? 2'(1 + $urandom % 3) : 2'(1 << ($urandom % 2));
      wr(ch, ADDR_SPR, 8'($urandom));
      rd_chk(0, ADDR_SPR, 8'(spr_m[0]));
      rd_chk(1, ADDR_SPR, 8'(spr_m[1]));
    end
  endtask
  task automatic prog(input logic [1:0] ch);
    wr(ch, ADDR_LCR, 8'h80);
    wr(ch, ADDR_DATA, 8'h01);
    wr(ch, ADDR_IER, 8'h00);
    wr(ch, ADDR_LCR, 8'h03);
  endtask
  task automatic serial(input int c);
    logic [7:0] b;
    logic [7:0] q;
    b = 8'($urandom);
    wr(2'(1 << c), ADDR_DATA, b);
    rxq[1 - c].push_back(b);
    q = 8'h00;
    for (int k = 0; k < 60 && !q[0]; k++) u_host.xfer(1'b1, 2'(1 << (1 - c)), ADDR_LSR, 8'h00, q);
    rd_chk(1 - c, ADDR_DATA, 8'(rxq[1 - c].pop_front()));
  endtask
  // Enhanced mode: 4X sampling, half-step fraction, divide-by-four prescaler
  task automatic fast(input logic [1:0] ch);
    wr(ch, ADDR_MCR, 8'h80);
    rd_chk(0, ADDR_MCR, 8'h00);
    wr(ch, ADDR_LCR, LCR_ENH_KEY);
    wr(ch, ADDR_ISR, 8'h10);
    wr(ch, ADDR_LCR, 8'h80);
    wr(ch, ADDR_ISR, 8'h28);
    rd_chk(0, ADDR_ISR, 8'h28);
    wr(ch, ADDR_MCR, 8'h80);
    rd_chk(0, ADDR_MCR, 8'h80);
    wr(ch, ADDR_LCR, 8'h03);
  endtask
  // Seventeen frames from B into A: sixteen kept, the last one overruns
  task automatic fill();
    logic [7:0] b;
    for (int i = 0; i < 17; i++) begin
      b = 8'($urandom);
      wr(2'h2, ADDR_DATA, b);
      if (i < 16) rxq[0].push_back(b);
    end
    repeat (3000) @(negedge clk);
    rd_chk(0, ADDR_LSR, 8'h63);
    while (rxq[0].size() > 0) rd_chk(0, ADDR_DATA, 8'(rxq[0].pop_front()));
  endtask
  // ===========================================================================
  // Verdict
  task automatic final_report();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    final_report();
  end
  initial begin
    void'($urandom(3));
    do_srst(1'b1);
    chk_defaults();
    spr_mix(8);
    pin_rst();
    chk_defaults();
    prog(2'h3);
    serial(0);
    serial(1);
    fast(2'h3);
    serial(0);
    do_srst(1'b0);
    chk_defaults();
    spr_mix(8);
    prog(2'h1);
    prog(2'h2);
    serial(1);
    fill();
    pin_rst();
    rd_chk(0, ADDR_SPR, 8'h00);
    rd_chk(1, ADDR_LCR, 8'h00);
    final_report();
  end
endmodule
`default_nettype wire
